/* File: src/gcr_pkg.sv */
/*
  Constants for the output control and calibration coefficient register bank.
  Assumes a register-select code and word-wide data from the serial framing logic.
*/
package gcr_pkg;
  localparam int unsigned RSEL_W = 3;
  localparam int unsigned COEF_W = 24;
  localparam int unsigned OCTL_W = 8;
  localparam int unsigned NUM_PAIRS = 5;
  localparam int unsigned IDX_W = 3;
  localparam logic [RSEL_W-1:0] RSEL_OUTPUT_CTRL = 3'h5;
  localparam logic [RSEL_W-1:0] RSEL_OFFSET = 3'h6;
  localparam logic [RSEL_W-1:0] RSEL_FULLSCALE = 3'h7;
  localparam logic [OCTL_W-1:0] OCTL_RESET = 8'h00;
  localparam logic [COEF_W-1:0] OFFSET_RESET = 24'h800000;
  // Bit positions in the output control register, bit 7 first on the wire
  localparam int unsigned BIT_RESERVED = 7;
  localparam int unsigned BIT_BRIDGE = 6;
  localparam int unsigned BIT_UPPER_EN = 5;
  localparam int unsigned BIT_LOWER_EN = 4;
  localparam int unsigned BIT_OUT3 = 3;
  localparam int unsigned BIT_OUT2 = 2;
  localparam int unsigned BIT_OUT1 = 1;
  localparam int unsigned BIT_OUT0 = 0;
  // Last pair index in pseudo-differential mode, shared by channels 4 to 7
  localparam logic [IDX_W-1:0] SHARED_PAIR = 3'h4;
  localparam logic [IDX_W-1:0] DIFF_PAIR_MASK = 3'h3;
endpackage

/* File: src/gcr_coef_bank.sv */
/*
  Five-entry bank of 24-bit calibration coefficients with host and engine writes.
  Assumes a single clock; engine writes take priority over host writes.
*/
`timescale 1ns/100ps
`default_nettype none
module gcr_coef_bank #(
  parameter logic [23:0] RESET_VAL = 24'h000000
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [gcr_pkg::IDX_W-1:0] host_idx,
  input wire logic host_we,
  input wire logic [gcr_pkg::COEF_W-1:0] host_wdata,
  input wire logic cal_we,
  input wire logic [gcr_pkg::IDX_W-1:0] cal_idx,
  input wire logic [gcr_pkg::COEF_W-1:0] cal_data,
  input wire logic load_we,
  input wire logic [gcr_pkg::COEF_W-1:0] load_data,
  input wire logic [gcr_pkg::IDX_W-1:0] rd_idx,
  output logic [gcr_pkg::COEF_W-1:0] rd_data
);
  import gcr_pkg::*;
  logic [COEF_W-1:0] mem_q [NUM_PAIRS];
  logic [COEF_W-1:0] mem_d [NUM_PAIRS];

  always_comb begin
    for (int i = 0; i < NUM_PAIRS; i++) begin
      mem_d[i] = mem_q[i];
      if (load_we) begin
        mem_d[i] = load_data;
      end else if (cal_we && cal_idx == IDX_W'(i)) begin
        mem_d[i] = cal_data;
      end else if (host_we && host_idx == IDX_W'(i)) begin
        mem_d[i] = host_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_PAIRS; i++) begin
        mem_q[i] <= RESET_VAL;
      end
    end else begin
      for (int i = 0; i < NUM_PAIRS; i++) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  always_comb begin
    rd_data = '0;
    for (int i = 0; i < NUM_PAIRS; i++) begin
      if (rd_idx == IDX_W'(i)) begin
        rd_data = mem_q[i];
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/gcr_regs.sv */
/*
  Output control register and offset/full-scale coefficient banks of the converter.
  Assumes serial framing supplies select code, write/read strobes and data in clk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module gcr_regs (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [gcr_pkg::RSEL_W-1:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [gcr_pkg::COEF_W-1:0] reg_wdata,
  output logic [gcr_pkg::COEF_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [3:0] channel_code,
  input wire logic pseudo_mode,
  input wire logic reference_select,
  input wire logic conv_quiet,
  input wire logic zero_cal_done,
  input wire logic [gcr_pkg::COEF_W-1:0] zero_cal_result,
  input wire logic full_cal_done,
  input wire logic [gcr_pkg::COEF_W-1:0] full_cal_result,
  input wire logic trim_load,
  input wire logic [gcr_pkg::COEF_W-1:0] trim_value,
  input wire logic [3:0] out_pin_in,
  output logic [3:0] out_pin_o,
  output logic [3:0] out_pin_oe,
  output logic bridge_switch_closed,
  output logic [gcr_pkg::IDX_W-1:0] active_pair,
  output logic [gcr_pkg::COEF_W-1:0] active_offset,
  output logic [gcr_pkg::COEF_W-1:0] active_fullscale
);
  import gcr_pkg::*;

  // ***************************************************
  // Pair index from channel and input mode
  // ***************************************************
  logic [IDX_W-1:0] pair_idx;
  always_comb begin
    if (pseudo_mode && channel_code[2]) begin
      pair_idx = SHARED_PAIR;
    end else begin
      pair_idx = channel_code[IDX_W-1:0] & DIFF_PAIR_MASK;
    end
  end

  // ***************************************************
  // Output control register
  // ***************************************************
  logic [OCTL_W-1:0] octl_q;
  logic [OCTL_W-1:0] octl_d;
  logic wr_octl;
  assign wr_octl = reg_wr && reg_sel == RSEL_OUTPUT_CTRL;

  always_comb begin
    octl_d = octl_q;
    if (wr_octl) begin
      octl_d = reg_wdata[OCTL_W-1:0];
      octl_d[BIT_RESERVED] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      octl_q <= OCTL_RESET;
    end else begin
      octl_q <= octl_d;
    end
  end

  // ***************************************************
  // Pin drivers and bridge switch
  // ***************************************************
  logic upper_pair_enable;
  logic lower_pair_enable;
  logic lower_drive;
  logic [3:0] pin_o_d;
  logic [3:0] pin_oe_d;
  logic bridge_d;
  assign upper_pair_enable = octl_q[BIT_UPPER_EN];
  assign lower_pair_enable = octl_q[BIT_LOWER_EN];
  assign lower_drive = lower_pair_enable && !reference_select;

  always_comb begin
    pin_o_d = octl_q[BIT_OUT3:BIT_OUT0];
    pin_oe_d = {upper_pair_enable, upper_pair_enable, lower_drive, lower_drive};
    bridge_d = octl_q[BIT_BRIDGE];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_pin_o <= 4'h0;
      out_pin_oe <= 4'h0;
      bridge_switch_closed <= 1'b0;
    end else begin
      out_pin_o <= pin_o_d;
      out_pin_oe <= pin_oe_d;
      bridge_switch_closed <= bridge_d;
    end
  end

  // ***************************************************
  // Coefficient banks
  // ***************************************************
  logic wr_off;
  logic wr_fs;
  logic [COEF_W-1:0] off_rd;
  logic [COEF_W-1:0] fs_rd;
  assign wr_off = reg_wr && reg_sel == RSEL_OFFSET && conv_quiet;
  assign wr_fs = reg_wr && reg_sel == RSEL_FULLSCALE && conv_quiet;

  gcr_coef_bank #(
    .RESET_VAL(OFFSET_RESET)
  ) u_offset_bank (
    .clk(clk),
    .arst_n(arst_n),
    .host_idx(pair_idx),
    .host_we(wr_off),
    .host_wdata(reg_wdata),
    .cal_we(zero_cal_done),
    .cal_idx(pair_idx),
    .cal_data(zero_cal_result),
    .load_we(1'b0),
    .load_data(OFFSET_RESET),
    .rd_idx(pair_idx),
    .rd_data(off_rd)
  );

  gcr_coef_bank #(
    .RESET_VAL(24'h000000)
  ) u_fullscale_bank (
    .clk(clk),
    .arst_n(arst_n),
    .host_idx(pair_idx),
    .host_we(wr_fs),
    .host_wdata(reg_wdata),
    .cal_we(full_cal_done),
    .cal_idx(pair_idx),
    .cal_data(full_cal_result),
    .load_we(trim_load),
    .load_data(trim_value),
    .rd_idx(pair_idx),
    .rd_data(fs_rd)
  );

  // ***************************************************
  // Readback
  // ***************************************************
  logic [COEF_W-1:0] rdata_d;
  logic [OCTL_W-1:0] octl_view;
  always_comb begin
    octl_view = octl_q;
    if (upper_pair_enable) begin
      octl_view[BIT_OUT3:BIT_OUT2] = out_pin_in[3:2];
    end
    if (lower_pair_enable) begin
      octl_view[BIT_OUT1:BIT_OUT0] = out_pin_in[1:0];
    end
    case (reg_sel)
      RSEL_OUTPUT_CTRL: rdata_d = {16'h0000, octl_view};
      RSEL_OFFSET: rdata_d = off_rd;
      RSEL_FULLSCALE: rdata_d = fs_rd;
      default: rdata_d = 24'h000000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 24'h000000;
      reg_rvalid <= 1'b0;
      active_pair <= 3'h0;
      active_offset <= OFFSET_RESET;
      active_fullscale <= 24'h000000;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
      active_pair <= pair_idx;
      active_offset <= off_rd;
      active_fullscale <= fs_rd;
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_reserved_bit_zero: assert property (octl_q[BIT_RESERVED] == 1'b0)
    else $error("reserved control bit set");
  a_bridge_follows: assert property (bridge_switch_closed == $past(octl_q[BIT_BRIDGE]))
    else $error("bridge switch does not follow its bit");
  a_bridge_in_pd: assert property (conv_quiet && octl_q[BIT_BRIDGE] |=> bridge_switch_closed)
    else $error("bridge switch opened in power-down");
  a_upper_float: assert property (!upper_pair_enable |=> out_pin_oe[3:2] == 2'b00)
    else $error("upper pair driven while disabled");
  a_lower_float: assert property (!lower_pair_enable |=> out_pin_oe[1:0] == 2'b00)
    else $error("lower pair driven while disabled");
  a_ref_select: assert property (reference_select |=> out_pin_oe[1:0] == 2'b00)
    else $error("pins driven while used as reference");
  a_upper_level: assert property (upper_pair_enable |=> out_pin_o[3:2] == $past(octl_q[3:2]))
    else $error("upper pin level mismatch");
  a_lower_level: assert property (lower_pair_enable |=> out_pin_o[1:0] == $past(octl_q[1:0]))
    else $error("lower pin level mismatch");
  sequence s_ctrl_read;
    reg_rd && reg_sel == RSEL_OUTPUT_CTRL && upper_pair_enable;
  endsequence
  a_pin_readback: assert property (s_ctrl_read |=> reg_rdata[3:2] == $past(out_pin_in[3:2]))
    else $error("readback does not show pin levels");
  a_ctrl_write: assert property (wr_octl |=> octl_q[6:0] == $past(reg_wdata[6:0]))
    else $error("control write not stored");
  a_offset_cal: assert property (
    zero_cal_done |-> ##2 (active_pair != $past(pair_idx, 2)
    || active_offset == $past(zero_cal_result, 2)))
    else $error("offset calibration not stored");

  // ***************************************************
  // Pin drive and pair mapping checks
  // ***************************************************
  a_upper_drive: assert property (upper_pair_enable |=> out_pin_oe[3:2] == 2'b11)
    else $error("upper pair not driven while enabled");
  a_lower_drive: assert property (
    lower_pair_enable && !reference_select |=> out_pin_oe[1:0] == 2'b11)
    else $error("lower pair not driven while enabled");
  a_shared_pair: assert property (
    pseudo_mode && channel_code[2] |=> active_pair == SHARED_PAIR)
    else $error("upper pseudo channels not on the shared pair");
  a_own_pair: assert property (
    !channel_code[2] |=> active_pair == {1'b0, $past(channel_code[1:0])})
    else $error("low channel not on its own pair");

  // ***************************************************
  // Read port checks
  // ***************************************************
  a_rvalid_pulse: assert property (reg_rvalid == $past(reg_rd))
    else $error("read valid not one cycle after the read strobe");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  sequence s_unmapped_read;
    reg_rd && reg_sel != RSEL_OUTPUT_CTRL && reg_sel != RSEL_OFFSET
      && reg_sel != RSEL_FULLSCALE;
  endsequence
  a_unmapped_zero: assert property (s_unmapped_read |=> reg_rdata == 24'h000000)
    else $error("unmapped select code read nonzero");

  // ***************************************************
  // Coefficient update checks
  // ***************************************************
  // Host write shows on the active pair two cycles later
  sequence s_host_offset_write;
    wr_off && !zero_cal_done;
  endsequence
  a_offset_write: assert property (
    s_host_offset_write |-> ##2 (active_pair != $past(pair_idx, 2)
    || active_offset == $past(reg_wdata, 2)))
    else $error("host offset write not stored");
  sequence s_host_fs_write;
    wr_fs && !full_cal_done && !trim_load;
  endsequence
  a_fullscale_write: assert property (
    s_host_fs_write |-> ##2 (active_pair != $past(pair_idx, 2)
    || active_fullscale == $past(reg_wdata, 2)))
    else $error("host full-scale write not stored");
  // Write while converting must leave the coefficient alone
  sequence s_busy_offset_write;
    reg_wr && reg_sel == RSEL_OFFSET && !conv_quiet && !zero_cal_done;
  endsequence
  a_busy_write_ignored: assert property (
    s_busy_offset_write ##1 $stable(pair_idx) |-> $stable(off_rd))
    else $error("offset changed by a write while converting");
  a_fullscale_cal: assert property (
    full_cal_done && !trim_load |-> ##2 (active_pair != $past(pair_idx, 2)
    || active_fullscale == $past(full_cal_result, 2)))
    else $error("full-scale calibration not stored");
  a_fullscale_trim: assert property (
    trim_load |-> ##2 active_fullscale == $past(trim_value, 2))
    else $error("factory trim not loaded");
endmodule
`default_nettype wire

/* File: test/gcr_pin_model.sv */
/*
  Outside circuit on the four general-purpose pins.
  Assumes the bench sets the level an undriven pin settles to.
*/
`timescale 1ns/100ps
`default_nettype none
module gcr_pin_model (
  input wire logic [3:0] out_pin_o,
  input wire logic [3:0] out_pin_oe,
  input wire logic [3:0] ext_level,
  output logic [3:0] out_pin_in
);
  // Released pins show the outside level, not the last drive
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      out_pin_in[i] = out_pin_oe[i] ? out_pin_o[i] : ext_level[i];
    end
  end
endmodule
`default_nettype wire

/* File: test/gpo_and_calibration_regs_bench.sv */
/*
  Self-checking bench for the register bank.
  Assumes gcr_pkg and the pin model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module gpo_and_calibration_regs_bench;
  import gcr_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pseudo_mode = 1'b0;
  logic reference_select = 1'b0, conv_quiet = 1'b0, zero_cal_done = 1'b0;
  logic full_cal_done = 1'b0, trim_load = 1'b0, reg_rvalid, bridge_switch_closed;
  logic [2:0] reg_sel = 3'h0, active_pair;
  logic [3:0] channel_code = 4'h0, ext_level = 4'h0, out_pin_in, out_pin_o, out_pin_oe;
  logic [23:0] reg_wdata = 24'h0, zero_cal_result = 24'h0, full_cal_result = 24'h0;
  logic [23:0] trim_value = 24'h0, reg_rdata, active_offset, active_fullscale;
  logic [23:0] off_e [5];
  int bad_count = 0;
  int comparisons = 0;
  always #2 clk = ~clk;
  gcr_regs i_dut (.clk(clk), .arst_n(arst_n), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .channel_code(channel_code), .pseudo_mode(pseudo_mode),
    .reference_select(reference_select), .conv_quiet(conv_quiet),
    .zero_cal_done(zero_cal_done), .zero_cal_result(zero_cal_result),
    .full_cal_done(full_cal_done), .full_cal_result(full_cal_result),
    .trim_load(trim_load), .trim_value(trim_value), .out_pin_in(out_pin_in),
    .out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe),
    .bridge_switch_closed(bridge_switch_closed), .active_pair(active_pair),
    .active_offset(active_offset), .active_fullscale(active_fullscale));
  gcr_pin_model i_pins (.out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe),
    .ext_level(ext_level), .out_pin_in(out_pin_in));
  // ****************
  // Access tasks
  // ****************
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] sel, input logic [23:0] data);
    @(posedge clk);
    reg_sel <= sel;
    reg_wdata <= (sel == RSEL_OUTPUT_CTRL) ? (data & 24'h00007F) : data;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] sel, input logic [23:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    reg_sel <= sel;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("read valid", 24'h1, {23'h0, reg_rvalid});
    chk("read data", exp, reg_rdata);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic pick(input logic p, input logic [3:0] ch);
    @(posedge clk);
    pseudo_mode <= p;
    channel_code <= ch;
    repeat (3) @(posedge clk);
  endtask
  task automatic cal(input int kind, input logic [23:0] data);
    @(posedge clk);
    zero_cal_done <= (kind == 0);
    full_cal_done <= (kind == 1);
    trim_load <= (kind == 2);
    zero_cal_result <= data;
    full_cal_result <= data;
    trim_value <= data;
    @(posedge clk);
    {zero_cal_done, full_cal_done, trim_load} <= 3'h0;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rd(RSEL_OUTPUT_CTRL, 24'h0);
    rd(RSEL_OFFSET, 24'h800000);
    $display("reset test done");
    foreach (off_e[i]) off_e[i] = 24'h800000;
    for (int k = 0; k < 2; k++) begin
      wr(RSEL_OUTPUT_CTRL, k ? 24'h3A : 24'h35);
      settle();
      chk("pin enables", 24'hF, out_pin_oe);
      chk("pin levels", k ? 24'hA : 24'h5, out_pin_o);
      rd(RSEL_OUTPUT_CTRL, k ? 24'h3A : 24'h35);
    end
    wr(RSEL_OUTPUT_CTRL, 24'h4A);
    settle();
    chk("pin enables", 24'h0, out_pin_oe);
    chk("bridge", 24'h1, bridge_switch_closed);
    rd(RSEL_OUTPUT_CTRL, 24'h4A);
    @(posedge clk);
    conv_quiet <= 1'b1;
    settle();
    chk("bridge", 24'h1, bridge_switch_closed);
    @(posedge clk);
    reference_select <= 1'b1;
    ext_level <= 4'h5;
    wr(RSEL_OUTPUT_CTRL, 24'h1A);
    settle();
    chk("pin enables", 24'h0, out_pin_oe);
    rd(RSEL_OUTPUT_CTRL, 24'h19);
    @(posedge clk);
    reference_select <= 1'b0;
    $display("pin test done");
    for (int i = 0; i < 5; i++) begin
      pick(1'b1, 4'(i));
      off_e[i] = 24'h100000 + 24'(i);
      wr(RSEL_OFFSET, off_e[i]);
      wr(RSEL_FULLSCALE, 24'h500000 + 24'(i));
      rd(RSEL_OFFSET, off_e[i]);
      rd(RSEL_FULLSCALE, 24'h500000 + 24'(i));
      chk("active pair", 24'(i), active_pair);
    end
    pick(1'b1, 4'h7);
    chk("active offset", off_e[4], active_offset);
    chk("active fullscale", 24'h500004, active_fullscale);
    pick(1'b0, 4'h5);
    rd(RSEL_OFFSET, off_e[1]);
    @(posedge clk);
    conv_quiet <= 1'b0;
    wr(RSEL_OFFSET, 24'hABCDEF);
    rd(RSEL_OFFSET, off_e[1]);
    cal(0, 24'h123456);
    rd(RSEL_OFFSET, 24'h123456);
    cal(1, 24'h654321);
    rd(RSEL_FULLSCALE, 24'h654321);
    cal(2, 24'h5ABCD0);
    rd(RSEL_FULLSCALE, 24'h5ABCD0);
    rd(3'h2, 24'h0);
    $display("coefficient test done");
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(RSEL_OFFSET, 24'h800000);
    rd(RSEL_OUTPUT_CTRL, 24'h0);
    $display("second reset test done");
    report_and_stop();
  end
  // Watchdog well beyond the expected run of about 140 cycles
  initial begin
    #(4 * 5000);
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
